// ### spl_start_protect_lock.sv
// spl_start_protect_lock: unattended start protection and parameter edit lock
// assumes rst marks power-up; run and keypad lines are already synchronous
`timescale 1ns/10ps
module spl_start_protect_lock #(
	parameter int N           = spl_pkg::NUM_INPUTS,
	parameter int RESET_CYC   = spl_pkg::RESET_PULSE_CYC
) (
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	// intelligent input terminals
	input  wire logic [N-1:0]                      term_in,
	input  wire logic [N-1:0][spl_pkg::FUNC_W-1:0] func_code,
	// run command and keypad
	input  wire logic                              run_cmd,
	input  wire logic                              keypad_reset,
	// undervoltage event from supply monitor
	input  wire logic                              undervoltage,
	// configuration
	input  wire logic                              freq_exclude_setting,
	// edit requests
	input  spl_pkg::spl_edit_req_t                 edit_req,
	output logic                                   edit_grant,
	// drive status
	output logic                                   motor_on_ff,
	output logic                                   trip_ff,
	output logic [7:0]                             err_code_ff
);
	spl_pkg::spl_func_t                 func_ff;
	spl_pkg::spl_state_t                state_ff;
	spl_pkg::spl_state_t                nxt_state;
	logic                               run_d_ff;
	logic                               rst_term_d_ff;
	logic [spl_pkg::CNT_W-1:0]          rst_cnt_ff;
	logic                               rst_long_ff;
	logic                               uv_trip_ff;
	logic                               reset_evt;
	logic                               run_rise;

	spl_input_route #(.N(N)) u_route (
		.clk_sys   (clk_sys),
		.term_in   (term_in),
		.func_code (func_code),
		.func_ff   (func_ff)
	);

	// reset terminal pulse width counter; short pulses are ignored as glitches
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rst_cnt_ff  <= '0;
			rst_long_ff <= 1'b0;
		end else if (func_ff.trip_reset) begin
			if (rst_cnt_ff >= spl_pkg::CNT_W'(RESET_CYC - 1)) begin
				rst_long_ff <= 1'b1;
			end else begin
				rst_cnt_ff <= rst_cnt_ff + 1'b1;
			end
		end else begin
			rst_cnt_ff  <= '0;
			rst_long_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rst_term_d_ff <= 1'b0;
			run_d_ff      <= 1'b0;
		end else begin
			rst_term_d_ff <= func_ff.trip_reset;
			run_d_ff      <= run_cmd;
		end
	end

	// reset acts on the falling edge of a long enough pulse, or the keypad key
	assign reset_evt = (rst_term_d_ff & ~func_ff.trip_reset & rst_long_ff) | keypad_reset;
	assign run_rise  = run_cmd & ~run_d_ff;

	// undervoltage trip: set wins over reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			uv_trip_ff <= 1'b0;
		end else if (undervoltage) begin
			uv_trip_ff <= 1'b1;
		end else if (reset_evt) begin
			uv_trip_ff <= 1'b0;
		end
	end

	// the first cycle out of reset is the power-up check
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			spl_pkg::SPL_PWRUP: begin
				if (run_cmd && func_ff.start_protect) begin
					nxt_state = spl_pkg::SPL_TRIP;
				end else if (run_cmd) begin
					nxt_state = spl_pkg::SPL_RUN;
				end else begin
					nxt_state = spl_pkg::SPL_IDLE;
				end
			end
			spl_pkg::SPL_IDLE: begin
				if (run_rise && !uv_trip_ff) begin
					nxt_state = spl_pkg::SPL_RUN;
				end else if (reset_evt && run_cmd && func_ff.start_protect) begin
					nxt_state = spl_pkg::SPL_TRIP;
				end
			end
			spl_pkg::SPL_RUN: begin
				if (!run_cmd || undervoltage) begin
					nxt_state = spl_pkg::SPL_IDLE;
				end
			end
			spl_pkg::SPL_TRIP: begin
				if (!run_cmd || reset_evt) begin
					nxt_state = spl_pkg::SPL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= spl_pkg::SPL_PWRUP;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			motor_on_ff <= 1'b0;
			trip_ff     <= 1'b0;
			err_code_ff <= spl_pkg::ERR_NONE;
		end else begin
			motor_on_ff <= (nxt_state == spl_pkg::SPL_RUN);
			trip_ff     <= (nxt_state == spl_pkg::SPL_TRIP) | uv_trip_ff;
			if (nxt_state == spl_pkg::SPL_TRIP) begin
				err_code_ff <= spl_pkg::ERR_START_PROT;
			end else if (uv_trip_ff) begin
				err_code_ff <= spl_pkg::ERR_UNDERVOLT;
			end else begin
				err_code_ff <= spl_pkg::ERR_NONE;
			end
		end
	end

	// edit gating applies to every request source alike
	always_comb begin
		edit_grant = edit_req.valid;
		if (func_ff.edit_lock) begin
			edit_grant = edit_req.valid & edit_req.is_freq & freq_exclude_setting;
		end
	end

	AST_TRIP_HOLDS_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		trip_ff && err_code_ff == spl_pkg::ERR_START_PROT |-> !motor_on_ff)
		else $error("motor on during start protect trip");
	AST_PWRUP_TRIP: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_PWRUP && run_cmd && func_ff.start_protect
		|=> err_code_ff == spl_pkg::ERR_START_PROT && state_ff == spl_pkg::SPL_TRIP)
		else $error("power-up run not trapped");
	AST_PWRUP_RUN: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_PWRUP && run_cmd && !func_ff.start_protect |=> motor_on_ff)
		else $error("power-up run not resumed");
	AST_CLEAR_ON_RUN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_TRIP && !run_cmd |=> state_ff == spl_pkg::SPL_IDLE)
		else $error("trip not cleared by run removal");
	AST_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_IDLE && run_rise && !uv_trip_ff |=> motor_on_ff)
		else $error("fresh run did not start output");
	AST_LOCK_BLOCKS: assert property (@(posedge clk_sys) disable iff (rst)
		func_ff.edit_lock && !edit_req.is_freq |-> !edit_grant)
		else $error("edit granted under lock");
	AST_FREQ_EXEMPT: assert property (@(posedge clk_sys) disable iff (rst)
		func_ff.edit_lock && edit_req.valid && edit_req.is_freq |-> edit_grant == freq_exclude_setting)
		else $error("frequency exclusion wrong");
	AST_UNLOCKED: assert property (@(posedge clk_sys) disable iff (rst)
		!func_ff.edit_lock |-> edit_grant == edit_req.valid)
		else $error("edit refused while unlocked");
	AST_UV_PROTECT: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_IDLE && reset_evt && run_cmd && func_ff.start_protect && !run_rise
		|=> state_ff == spl_pkg::SPL_TRIP)
		else $error("protection skipped after reset");
	// from_remote is carried only so that the lock can be shown to cover both sources
	AST_REMOTE_LOCKED: assert property (@(posedge clk_sys) disable iff (rst)
		func_ff.edit_lock && edit_req.valid && edit_req.from_remote
		&& !(edit_req.is_freq && freq_exclude_setting) |-> !edit_grant)
		else $error("remote edit granted under lock");
	AST_KEYPAD_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_TRIP && keypad_reset |=> state_ff == spl_pkg::SPL_IDLE)
		else $error("keypad reset did not clear trip");
	AST_TRIP_CODE: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_TRIP
		|-> trip_ff && !motor_on_ff && err_code_ff == spl_pkg::ERR_START_PROT)
		else $error("trip state without trip outputs");
	// the undervoltage flag takes one cycle before it reaches the status outputs
	AST_UV_TRIPS: assert property (@(posedge clk_sys) disable iff (rst)
		undervoltage |-> ##2 (trip_ff && err_code_ff != spl_pkg::ERR_NONE))
		else $error("undervoltage did not trip");
	AST_UV_STOPS: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_RUN && undervoltage |=> !motor_on_ff)
		else $error("motor kept on after undervoltage");
	AST_RUN_OFF_STOPS: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == spl_pkg::SPL_RUN && !run_cmd |=> !motor_on_ff)
		else $error("motor kept on after run removal");
	// the width counter saturates, so a held terminal never wraps into a short pulse
	AST_RESET_WIDTH: assert property (@(posedge clk_sys) disable iff (rst)
		rst_long_ff |-> rst_cnt_ff == spl_pkg::CNT_W'(RESET_CYC - 1))
		else $error("reset width flag without full count");
endmodule : spl_start_protect_lock

// ### spl_pkg.sv
// spl_pkg: shared constants and carriers for start protection and edit lock
// assumes a single 200 MHz system clock and synchronous active-high reset
package spl_pkg;
	localparam int          CLK_MHZ         = 200;
	localparam int          NUM_INPUTS      = 5;
	localparam int          FUNC_W          = 5;
	localparam logic [4:0]  FUNC_START_PROT = 5'h0D;
	localparam logic [4:0]  FUNC_EDIT_LOCK  = 5'h0F;
	localparam logic [4:0]  FUNC_TRIP_RESET = 5'h12;
	localparam logic [7:0]  ERR_NONE        = 8'h00;
	localparam logic [7:0]  ERR_START_PROT  = 8'h0D;
	localparam logic [7:0]  ERR_UNDERVOLT   = 8'h09;
	localparam int          RESET_PULSE_MS  = 12;
	localparam int          RESET_PULSE_CYC = RESET_PULSE_MS * CLK_MHZ * 1000;
	localparam int          CNT_W           = 22;

	// one edit request from keypad or remote programming device
	typedef struct packed {
		logic       valid;
		logic       is_freq;
		logic       from_remote;
	} spl_edit_req_t;

	// routed levels of the intelligent inputs
	typedef struct packed {
		logic       start_protect;
		logic       edit_lock;
		logic       trip_reset;
	} spl_func_t;

	typedef enum logic [1:0] {
		SPL_PWRUP = 2'h0,
		SPL_IDLE  = 2'h1,
		SPL_RUN   = 2'h3,
		SPL_TRIP  = 2'h2
	} spl_state_t;
endpackage : spl_pkg

// ### spl_input_route.sv
// spl_input_route: synchronises terminals and routes them by function code
// assumes terminal levels are asynchronous pins, function codes are static config
// assumes the clock runs through reset, so routed levels are settled at release
`timescale 1ns/10ps
module spl_input_route #(
	parameter int N = spl_pkg::NUM_INPUTS
) (
	// clock
	input  wire logic                              clk_sys,
	// terminals and their configured function codes
	input  wire logic [N-1:0]                      term_in,
	input  wire logic [N-1:0][spl_pkg::FUNC_W-1:0] func_code,
	// routed functions
	output spl_pkg::spl_func_t                     func_ff
);
	logic [N-1:0] meta_ff;
	logic [N-1:0] sync_ff;

	function automatic logic any_with(input logic [N-1:0] lvl,
		input logic [N-1:0][spl_pkg::FUNC_W-1:0] code, input logic [4:0] f);
		logic r;
		r = 1'b0;
		for (int i = 0; i < N; i++) begin
			r = r | (lvl[i] & (code[i] == f));
		end
		return r;
	endfunction : any_with

	// no reset here: a reset pipeline would hide a held terminal from the power-up check
	always_ff @(posedge clk_sys) begin
		meta_ff <= term_in;
		sync_ff <= meta_ff;
	end

	always_ff @(posedge clk_sys) begin
		func_ff.start_protect <= any_with(sync_ff, func_code, spl_pkg::FUNC_START_PROT);
		func_ff.edit_lock     <= any_with(sync_ff, func_code, spl_pkg::FUNC_EDIT_LOCK);
		func_ff.trip_reset    <= any_with(sync_ff, func_code, spl_pkg::FUNC_TRIP_RESET);
	end
endmodule : spl_input_route

// ### spl_far_model.sv
// spl_far_model: terminals, run command, keypad and remote editor of the far side
// assumes the caller steps it shortly after a rising clk_sys edge
`timescale 1ns/10ps
module spl_far_model #(
	parameter int N = spl_pkg::NUM_INPUTS
) (
	// clock
	input  wire logic              clk_sys,
	// terminal levels and operator lines
	output logic [N-1:0]           term_in,
	output logic                   run_cmd,
	output logic                   keypad_reset,
	output spl_pkg::spl_edit_req_t edit_req
);
	initial begin
		term_in      = '0;
		run_cmd      = 1'b0;
		keypad_reset = 1'b0;
		edit_req     = '0;
	end

	task automatic set_term(input int idx, input logic v);
		term_in[idx] = v;
	endtask : set_term

	// the caller owes the settle time after power-up before raising run
	task automatic set_run(input logic v);
		run_cmd = v;
	endtask : set_run

	// width is the caller's choice so that a too-short pulse can be tried
	task automatic pulse_reset(input int cyc);
		term_in[2] = 1'b1;
		repeat (cyc) @(posedge clk_sys);
		#1;
		term_in[2] = 1'b0;
	endtask : pulse_reset

	task automatic key_reset();
		keypad_reset = 1'b1;
		@(posedge clk_sys);
		#1;
		keypad_reset = 1'b0;
	endtask : key_reset

	task automatic edit(input logic v, input logic is_freq, input logic remote);
		edit_req = {v, is_freq, remote};
	endtask : edit
endmodule : spl_far_model

// ### tb_top.sv
// tb_top: self-checking bench for start protection and edit lock
// assumes input 0 start protect, 1 edit lock, 2 trip reset; short reset count
`timescale 1ns/10ps
module tb_top;
	localparam int RCYC = 4;
	logic                                                 clk_sys = 1'b0;
	logic                                                 rst = 1'b1;
	logic                                                 undervoltage = 1'b0;
	logic                                                 freq_exclude_setting = 1'b0;
	logic [spl_pkg::NUM_INPUTS-1:0]                       term_in;
	logic [spl_pkg::NUM_INPUTS-1:0][spl_pkg::FUNC_W-1:0] func_code;
	logic                                                 run_cmd;
	logic                                                 keypad_reset;
	logic                                                 edit_grant;
	logic                                                 motor_on_ff;
	logic                                                 trip_ff;
	logic [7:0]                                           err_code_ff;
	spl_pkg::spl_edit_req_t                               edit_req;
	int                                                   miscompares = 0;
	int                                                   checked = 0;

	always #2.5 clk_sys = ~clk_sys;
	assign func_code = {5'h00, 5'h00, spl_pkg::FUNC_TRIP_RESET, spl_pkg::FUNC_EDIT_LOCK,
		spl_pkg::FUNC_START_PROT};

	spl_far_model i_far (.clk_sys(clk_sys), .term_in(term_in), .run_cmd(run_cmd),
		.keypad_reset(keypad_reset), .edit_req(edit_req));

	spl_start_protect_lock #(.RESET_CYC(RCYC)) i_dut (.clk_sys(clk_sys), .rst(rst),
		.term_in(term_in), .func_code(func_code), .run_cmd(run_cmd),
		.keypad_reset(keypad_reset), .undervoltage(undervoltage),
		.freq_exclude_setting(freq_exclude_setting), .edit_req(edit_req),
		.edit_grant(edit_grant), .motor_on_ff(motor_on_ff), .trip_ff(trip_ff),
		.err_code_ff(err_code_ff));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	// reset spans four edges at start; routing lags three, so terminals settle inside it
	task automatic power_up(input logic sp, input logic run);
		cyc(1);
		rst = 1'b1;
		i_far.set_term(0, sp);
		i_far.set_run(run);
		cyc(3);
		rst = 1'b0;
		cyc(2);
	endtask : power_up

	task automatic t_no_protect();
		power_up(1'b0, 1'b1);
		check(motor_on_ff, 1'b1, "motor after plain power-up");
		check(trip_ff, 1'b0, "no trip without protection");
	endtask : t_no_protect

	task automatic t_protect_run_clear();
		power_up(1'b1, 1'b1);
		check(motor_on_ff, 1'b0, "motor held off");
		check(trip_ff, 1'b1, "protect trip");
		check(err_code_ff, spl_pkg::ERR_START_PROT, "protect code");
		i_far.set_run(1'b0);
		cyc(1);
		check(trip_ff, 1'b0, "trip cleared by run off");
		cyc(3);
		i_far.set_run(1'b1);
		cyc(1);
		check(motor_on_ff, 1'b1, "fresh run starts");
	endtask : t_protect_run_clear

	task automatic t_keypad_clear();
		power_up(1'b1, 1'b1);
		i_far.set_term(0, 1'b0);
		cyc(5);
		i_far.key_reset();
		cyc(1);
		check(trip_ff, 1'b0, "keypad clears trip");
		check(err_code_ff, spl_pkg::ERR_NONE, "code cleared");
	endtask : t_keypad_clear

	task automatic t_undervolt();
		power_up(1'b1, 1'b0);
		i_far.set_run(1'b1);
		cyc(2);
		check(motor_on_ff, 1'b1, "run from idle");
		undervoltage = 1'b1;
		cyc(1);
		undervoltage = 1'b0;
		cyc(1);
		check(err_code_ff, spl_pkg::ERR_UNDERVOLT, "undervoltage code");
		check(motor_on_ff, 1'b0, "undervoltage stops");
		i_far.pulse_reset(RCYC - 2);
		cyc(8);
		check(err_code_ff, spl_pkg::ERR_UNDERVOLT, "short reset ignored");
		i_far.pulse_reset(RCYC + 2);
		cyc(8);
		check(trip_ff, 1'b1, "protection after reset");
		check(err_code_ff, spl_pkg::ERR_START_PROT, "protect code after reset");
		check(motor_on_ff, 1'b0, "no restart after reset");
	endtask : t_undervolt

	task automatic t_edit_lock();
		logic [2:0] i;
		power_up(1'b0, 1'b0);
		i_far.set_term(1, 1'b1);
		cyc(5);
		for (int k = 0; k < 8; k++) begin
			i = k[2:0];
			freq_exclude_setting = i[0];
			i_far.edit(1'b1, i[1], i[2]);
			#1;
			check(edit_grant, i[1] & i[0], "grant under lock");
			cyc(1);
		end
		i_far.set_term(1, 1'b0);
		cyc(5);
		i_far.edit(1'b1, 1'b0, 1'b1);
		#1;
		check(edit_grant, 1'b1, "grant after unlock");
		i_far.edit(1'b0, 1'b0, 1'b0);
	endtask : t_edit_lock

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		miscompares++;
		final_report();
	end

	initial begin
		t_no_protect();
		t_protect_run_clear();
		t_keypad_clear();
		t_undervolt();
		t_edit_lock();
		final_report();
	end
endmodule : tb_top
